// >>> core/actl_decode.sv
/*
  Registered decode of the control fields into amplifier enables, gain,
  sample framing and mute drive.  Assumes fields come from the bank.
*/
`timescale 1ns/1ps
`default_nettype none

module actl_decode import actl_pkg::*; (
  // Clock, reset and enable.
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Control fields.
  input  wire logic       amp_sleep,
  input  wire logic       amp_power_on_n,
  input  wire logic [1:0] digital_boost,
  input  wire logic [2:0] input_format,
  input  wire logic       mute_left,
  input  wire logic       mute_right,
  // Decoded controls.
  output logic            power_stage_en,
  output logic            standby_en,
  output logic [4:0]      boost_db,
  output logic [4:0]      sample_width,
  output logic            fmt_i2s,
  output logic            fmt_left_just,
  output logic            bal_left,
  output logic            bal_right
);

  logic [4:0] next_boost_db;
  logic [4:0] next_width;
  logic       next_i2s;
  logic       next_lj;

  // ----------------------------------------------------------------
  // Decode.  Reserved format codes fall back to I2S framing.
  // ----------------------------------------------------------------
  always_comb begin
    next_boost_db = 5'({3'h0, digital_boost} * BOOST_STEP_DB);
    next_width = WIDTH_24;
    next_i2s = 1'b0;
    next_lj = 1'b0;
    case (input_format)
      FMT_RJ24: next_width = WIDTH_24;
      FMT_RJ20: next_width = WIDTH_20;
      FMT_RJ18: next_width = WIDTH_18;
      FMT_RJ16: next_width = WIDTH_16;
      FMT_LJ:   next_lj = 1'b1;
      default:  next_i2s = 1'b1;
    endcase
  end

  // Registers; sleep keeps standby while shutdown drops both.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_stage_en <= 1'b0;
      standby_en <= 1'b0;
      boost_db <= 5'h00;
      sample_width <= WIDTH_24;
      fmt_i2s <= 1'b0;
      fmt_left_just <= 1'b0;
      bal_left <= 1'b0;
      bal_right <= 1'b0;
    end else if (ce) begin
      power_stage_en <= amp_power_on_n & ~amp_sleep;
      standby_en <= amp_power_on_n;
      boost_db <= next_boost_db;
      sample_width <= next_width;
      fmt_i2s <= next_i2s;
      fmt_left_just <= next_lj;
      bal_left <= mute_left;
      bal_right <= mute_right;
    end
  end

endmodule // actl_decode

`default_nettype wire

// >>> core/actl_pkg.sv
/*
  Constants, reset values and state types for the amplifier control
  register bank: the four control registers and their control port.
  Assumes a single 125 MHz clock and the control port pins already
  brought into that clock domain by the two-flop synchroniser.
*/
// Summary of operation
// - Power control bits 7:2 feed clip threshold.
// - Sleep bit stops power stage, standby kept.
// - Shutdown bit low powers down both domains.
// - Digital bit 7 skips the high-pass filter.
// - Boost code adds 0, 6, 12, 18 dB.
// - Speed bit picks single or double rates.
// - Format field selects serial input framing.
// - Fade bit enables gradual volume changes.
// - Right mute gives balanced output duty.
// - Left mute gives balanced output duty.
// - Write: address, register, data, acknowledged each.
// - Read: pointer write, restart, byte, not-acknowledge.
`default_nettype none

package actl_pkg;

  // ----------------------------------------------------------------
  // Register offsets and control port address.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ID  = 8'h00;
  localparam logic [7:0] OFF_PWR = 8'h01;
  localparam logic [7:0] OFF_DIG = 8'h02;
  localparam logic [7:0] OFF_VOL = 8'h03;
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam logic [7:0] ID_VALUE = 8'h5a;  // Arbitrary identity value.

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int PWR_CLIP_MSB = 7;
  localparam int PWR_CLIP_LSB = 2;
  localparam int PWR_SLEEP_BIT = 1;
  localparam int PWR_SD_BIT = 0;
  localparam int DIG_HPF_BIT = 7;
  localparam int DIG_BOOST_MSB = 5;
  localparam int DIG_BOOST_LSB = 4;
  localparam int DIG_SPEED_BIT = 3;
  localparam int DIG_FMT_MSB = 2;
  localparam int VOL_FADE_BIT = 7;
  localparam int VOL_MUTER_BIT = 1;
  localparam int VOL_MUTEL_BIT = 0;

  // ----------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_CLIP = 6'h3f;
  localparam logic RST_SLEEP = 1'b0;
  localparam logic RST_PWR_ON_N = 1'b1;
  localparam logic RST_HPF = 1'b0;
  localparam logic [1:0] RST_BOOST = 2'h1;
  localparam logic RST_SPEED = 1'b0;
  localparam logic [2:0] RST_FMT = 3'h4;
  localparam logic RST_FADE = 1'b1;
  localparam logic RST_MUTE = 1'b0;

  // ----------------------------------------------------------------
  // Serial format codes, sample widths, gain step and bit count.
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_RJ24 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ18 = 3'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h3;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LJ = 3'h5;
  localparam logic [4:0] WIDTH_24 = 5'h18;
  localparam logic [4:0] WIDTH_20 = 5'h14;
  localparam logic [4:0] WIDTH_18 = 5'h12;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] BOOST_STEP_DB = 5'h06;
  localparam logic [3:0] BIT_COUNT = 4'h8;

  // ----------------------------------------------------------------
  // Control port states and byte kinds.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} actl_state_e;
  typedef enum logic [1:0] {KIND_ADDR, KIND_PTR, KIND_DATA} actl_kind_e;

endpackage

`default_nettype wire

// >>> core/actl_reg_bank.sv
/*
  Amplifier control register bank behind a two-wire control port.
  Holds identity, power, digital path and volume configuration.
  Assumes an external pull-up on the data line and a 125 MHz ref_clk
  much faster than the serial clock.
*/
`timescale 1ns/1ps
`default_nettype none

module actl_reg_bank import actl_pkg::*; (
  // Clock, reset and enable.
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Control port pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Power control fields.
  output logic [5:0]      clip_threshold_hi,
  output logic            amp_sleep,
  output logic            amp_power_on_n,
  // Digital path fields.
  output logic            highpass_skip,
  output logic [1:0]      digital_boost,
  output logic            rate_speed_select,
  output logic [2:0]      input_format,
  // Volume configuration fields.
  output logic            fade_enable,
  output logic            mute_right,
  output logic            mute_left,
  // Decoded controls.
  output logic            power_stage_en,
  output logic            standby_en,
  output logic [4:0]      boost_db,
  output logic [4:0]      sample_width,
  output logic            fmt_i2s,
  output logic            fmt_left_just,
  output logic            bal_left,
  output logic            bal_right
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  actl_state_e state;
  actl_state_e next_state;
  actl_kind_e  kind;
  actl_kind_e  next_kind;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  pointer;
  logic [7:0]  next_pointer;
  logic        rd_mode;
  logic        next_rd_mode;
  logic        acked;
  logic        next_acked;
  logic        next_oe_n;
  logic        wr_strobe;
  logic [7:0]  read_data;
  logic [5:0]  clip_field;
  logic [5:0]  next_clip;
  logic        next_sleep;
  logic        next_pwr_on_n;
  logic        next_hpf;
  logic [1:0]  next_boost;
  logic        next_speed;
  logic [2:0]  next_fmt;
  logic        next_fade;
  logic        next_mute_r;
  logic        next_mute_l;

  // ----------------------------------------------------------------
  // Pin synchronisation and bus conditions.
  // ----------------------------------------------------------------

  // Both pins cross into ref_clk before any logic reads them.
  actl_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .din     ({scl_in, sda_in}),
    .dout    (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous pin levels for edge and condition detection.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Data moving while the clock is high marks start or stop.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Control port state machine.
  // ----------------------------------------------------------------

  // Bits are taken on the clock rise and driven after the fall, so
  // the data line never moves while the clock is high.
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cnt = cnt;
    next_shreg = shreg;
    next_pointer = pointer;
    next_rd_mode = rd_mode;
    next_acked = acked;
    next_oe_n = sda_oe_n;
    wr_strobe = 1'b0;
    if (stop_det) begin
      next_state = ST_IDLE;
      next_oe_n = 1'b1;
    end else if (start_det) begin
      next_state = ST_RX;
      next_kind = KIND_ADDR;
      next_cnt = 4'h0;
      next_oe_n = 1'b1;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise && cnt != BIT_COUNT) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BIT_COUNT) begin
            next_state = ST_ACK;
            next_oe_n = 1'b0;
            next_kind = KIND_DATA;
            if (kind == KIND_ADDR) begin
              next_rd_mode = shreg[0];
              if (shreg[7:1] != DEV_ADDR) begin
                next_state = ST_IDLE;
                next_oe_n = 1'b1;
              end else if (!shreg[0]) begin
                next_kind = KIND_PTR;
              end
            end else if (kind == KIND_PTR) begin
              next_pointer = shreg;
            end else begin
              wr_strobe = 1'b1;
              next_pointer = pointer + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rd_mode) begin
              next_state = ST_TX;
              next_shreg = read_data;
              next_oe_n = read_data[7];
            end else begin
              next_state = ST_RX;
              next_oe_n = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt == BIT_COUNT - 4'h1) begin
              next_state = ST_TXACK;
              next_oe_n = 1'b1;
              next_pointer = pointer + 8'h01;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_cnt = cnt + 4'h1;
              next_oe_n = shreg[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            next_acked = ~sda_s;
          end else if (scl_fall) begin
            if (acked) begin
              next_state = ST_TX;
              next_cnt = 4'h0;
              next_shreg = read_data;
              next_oe_n = read_data[7];
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // State registers; the data pin itself is only ever pulled low.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      kind <= KIND_ADDR;
      cnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      rd_mode <= 1'b0;
      acked <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      kind <= next_kind;
      cnt <= next_cnt;
      shreg <= next_shreg;
      pointer <= next_pointer;
      rd_mode <= next_rd_mode;
      acked <= next_acked;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------

  // Only writable fields are stored; identity and reserved bits have
  // no storage, so a write can never disturb them.
  always_comb begin
    next_clip = clip_threshold_hi;
    next_sleep = amp_sleep;
    next_pwr_on_n = amp_power_on_n;
    next_hpf = highpass_skip;
    next_boost = digital_boost;
    next_speed = rate_speed_select;
    next_fmt = input_format;
    next_fade = fade_enable;
    next_mute_r = mute_right;
    next_mute_l = mute_left;
    if (wr_strobe) begin
      if (pointer == OFF_PWR) begin
        next_clip = shreg[PWR_CLIP_MSB:PWR_CLIP_LSB];
        next_sleep = shreg[PWR_SLEEP_BIT];
        next_pwr_on_n = shreg[PWR_SD_BIT];
      end else if (pointer == OFF_DIG) begin
        next_hpf = shreg[DIG_HPF_BIT];
        next_boost = shreg[DIG_BOOST_MSB:DIG_BOOST_LSB];
        next_speed = shreg[DIG_SPEED_BIT];
        next_fmt = shreg[DIG_FMT_MSB:0];
      end else if (pointer == OFF_VOL) begin
        next_fade = shreg[VOL_FADE_BIT];
        next_mute_r = shreg[VOL_MUTER_BIT];
        next_mute_l = shreg[VOL_MUTEL_BIT];
      end
    end
  end

  // Field registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clip_threshold_hi <= RST_CLIP;
      amp_sleep <= RST_SLEEP;
      amp_power_on_n <= RST_PWR_ON_N;
      highpass_skip <= RST_HPF;
      digital_boost <= RST_BOOST;
      rate_speed_select <= RST_SPEED;
      input_format <= RST_FMT;
      fade_enable <= RST_FADE;
      mute_right <= RST_MUTE;
      mute_left <= RST_MUTE;
    end else if (ce) begin
      clip_threshold_hi <= next_clip;
      amp_sleep <= next_sleep;
      amp_power_on_n <= next_pwr_on_n;
      highpass_skip <= next_hpf;
      digital_boost <= next_boost;
      rate_speed_select <= next_speed;
      input_format <= next_fmt;
      fade_enable <= next_fade;
      mute_right <= next_mute_r;
      mute_left <= next_mute_l;
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero.
  always_comb begin
    read_data = 8'h00;
    if (pointer == OFF_ID) begin
      read_data = ID_VALUE;
    end else if (pointer == OFF_PWR) begin
      read_data = {clip_threshold_hi, amp_sleep, amp_power_on_n};
    end else if (pointer == OFF_DIG) begin
      read_data = {highpass_skip, 1'b0, digital_boost, rate_speed_select, input_format};
    end else if (pointer == OFF_VOL) begin
      read_data = {fade_enable, 5'h00, mute_right, mute_left};
    end
  end

  assign clip_field = shreg[PWR_CLIP_MSB:PWR_CLIP_LSB];

  // ----------------------------------------------------------------
  // Decode of fields into amplifier controls.
  // ----------------------------------------------------------------
  actl_decode u_decode (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .ce             (ce),
    .amp_sleep      (amp_sleep),
    .amp_power_on_n (amp_power_on_n),
    .digital_boost  (digital_boost),
    .input_format   (input_format),
    .mute_left      (mute_left),
    .mute_right     (mute_right),
    .power_stage_en (power_stage_en),
    .standby_en     (standby_en),
    .boost_db       (boost_db),
    .sample_width   (sample_width),
    .fmt_i2s        (fmt_i2s),
    .fmt_left_just  (fmt_left_just),
    .bal_left       (bal_left),
    .bal_right      (bal_right)
  );

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_byte_end;
    state == ST_RX && scl_fall && cnt == BIT_COUNT && ce && !start_det && !stop_det;
  endsequence

  sequence s_data_write;
    s_byte_end ##0 kind == KIND_DATA;
  endsequence

  AST_CLIP_LOAD: assert property (
    s_data_write ##0 pointer == OFF_PWR |=> clip_threshold_hi == $past(clip_field))
    else $error("Clip threshold did not take the written bits.");
  AST_SLEEP_STAGE_OFF: assert property (
    amp_sleep && amp_power_on_n && ce |=> !power_stage_en && standby_en)
    else $error("Sleep did not stop the power stage.");
  AST_SHUTDOWN_RESET: assert property ($past(reset) |-> amp_power_on_n)
    else $error("Shutdown control not released after reset.");
  AST_SHUTDOWN_DOMAINS: assert property (
    !amp_power_on_n && ce |=> !standby_en && !power_stage_en)
    else $error("Shutdown left a domain powered.");
  AST_HPF_LOAD: assert property (
    s_data_write ##0 pointer == OFF_DIG |=> highpass_skip == $past(shreg[DIG_HPF_BIT]))
    else $error("Filter skip bit did not take the written value.");
  AST_RSV_ZERO: assert property (
    pointer == OFF_VOL |-> read_data[6:2] == 5'h00)
    else $error("Reserved volume bits read non-zero.");
  AST_BOOST_DB: assert property (
    ce && !reset |=> boost_db == 5'({3'h0, $past(digital_boost)} * BOOST_STEP_DB))
    else $error("Boost gain does not match the code.");
  AST_FMT_RESET: assert property (
    $past(reset) |-> input_format == RST_FMT && rate_speed_select == RST_SPEED)
    else $error("Format or speed not at reset value.");
  AST_FADE_RESET: assert property ($past(reset) |-> fade_enable)
    else $error("Fade not enabled after reset.");
  AST_MUTE_BALANCE: assert property (
    ce |=> bal_right == $past(mute_right) && bal_left == $past(mute_left))
    else $error("Mute did not reach the balanced output drive.");
  AST_ACK_DRIVE: assert property (
    s_byte_end ##0 kind != KIND_ADDR |=> !sda_oe_n ##1 (!sda_oe_n)[*1])
    else $error("Received byte was not acknowledged.");
  AST_NACK_RELEASE: assert property (
    state == ST_TXACK && scl_fall && !acked && ce && !start_det && !stop_det
    |=> state == ST_IDLE && sda_oe_n)
    else $error("Not-acknowledge did not end the read.");
  AST_ID_IGNORED: assert property (
    s_data_write ##0 pointer == OFF_ID |=> $stable({clip_threshold_hi, amp_sleep, amp_power_on_n,
      highpass_skip, digital_boost, rate_speed_select, input_format, fade_enable, mute_right,
      mute_left}))
    else $error("Identity write disturbed the bank.");

endmodule // actl_reg_bank

`default_nettype wire

// >>> core/actl_sync.sv
/*
  Two-flop synchroniser for the control port pins.
  Assumes the inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module actl_sync #(
  parameter int WIDTH = 2
) (
  // Clock, reset and enable.
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Asynchronous in, synchronised out.
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // One flop pair per bit; the first stage feeds only the second.
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic next_meta;
      logic next_out;
      // Next values of the pair.
      always_comb begin
        next_meta = din[i];
        next_out = meta;
      end
      // Registers; idle bus level is high.
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          meta <= 1'b1;
          dout[i] <= 1'b1;
        end else if (ce) begin
          meta <= next_meta;
          dout[i] <= next_out;
        end
      end
    end
  endgenerate

endmodule // actl_sync

`default_nettype wire

// >>> testbench/actl_host_model.sv
/*
  Host controller model for the two-wire control port of the register bank.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module actl_host_model import actl_pkg::*; (
  // Clock.
  input  wire logic ref_clk,
  // Bus pins.
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  // ------------------------------------------------------------
  // Bus cycle tasks.
  // ------------------------------------------------------------
  logic [7:0] ack_miss = 8'h00;  // Bytes that the device left unacknowledged.

  // The bus idles released so the first START is a clean falling edge.
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  task automatic half;
    repeat (8) @(posedge ref_clk);
  endtask

  // Data moves mid-low, never beside an edge of the clock line.
  task automatic xbit(input logic b, output logic r);
    half();
    sda_oe_n <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask

  // Also serves as a repeated START after an acknowledge.
  task automatic start;
    half();
    sda_oe_n <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_oe_n <= 1'b0;
    half();
    scl <= 1'b0;
  endtask

  task automatic stop;
    half();
    sda_oe_n <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_oe_n <= 1'b1;
    half();
  endtask

  // One byte, MSB first; a read byte ends with a not-acknowledge.
  task automatic xbyte(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(1'b1, a);
    if (!rd && a !== 1'b0) ack_miss += 8'h01;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b0, q);
    xbyte(a, 1'b0, q);
    xbyte(d, 1'b0, q);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b0, q);
    xbyte(a, 1'b0, q);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b0, q);
    xbyte(8'hff, 1'b1, d);
    stop();
  endtask
endmodule // actl_host_model

`default_nettype wire

// >>> testbench/actl_reg_bank_test.sv
/*
  Self-checking bench for the register bank, driven through the host model.
  Assumes one 125 MHz clock and a pull-up on the data line.
*/
`timescale 1ns/1ps
`default_nettype none

module actl_reg_bank_test import actl_pkg::*;;
  // ------------------------------------------------------------
  // Signals and instances.
  // ------------------------------------------------------------
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       ce = 1'b1;
  logic       scl, h_oe_n, sda_out, sda_oe_n, sda;
  logic [5:0] clip_threshold_hi;
  logic [1:0] digital_boost;
  logic [2:0] input_format;
  logic [4:0] boost_db, sample_width;
  logic       amp_sleep, amp_power_on_n, highpass_skip, rate_speed_select, fade_enable;
  logic       mute_right, mute_left, power_stage_en, standby_en, fmt_i2s, fmt_left_just;
  logic       bal_left, bal_right;
  logic [7:0] v, q;
  logic [7:0] rstv [4] = '{ID_VALUE, 8'hfd, 8'h14, 8'h80};
  logic [4:0] wtab [6] = '{5'h18, 5'h14, 5'h12, 5'h10, 5'h18, 5'h18};
  int         n_fail = 0;
  int         cmp_count = 0;

  // Open-drain line: either party pulls low, the pull-up wins otherwise.
  assign sda = h_oe_n & (sda_oe_n | sda_out);

  always #4 ref_clk = ~ref_clk;

  actl_host_model host (.ref_clk, .sda, .scl, .sda_oe_n(h_oe_n));

  actl_reg_bank uut (.ref_clk, .reset, .ce, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .clip_threshold_hi, .amp_sleep, .amp_power_on_n, .highpass_skip, .digital_boost,
    .rate_speed_select, .input_format, .fade_enable, .mute_right, .mute_left,
    .power_stage_en, .standby_en, .boost_db, .sample_width, .fmt_i2s, .fmt_left_just,
    .bal_left, .bal_right);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence; every bus cycle takes 960 clocks at most.
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int a = 0; a < 4; a++) begin
      host.rd(a[7:0], q);
      chk(q, rstv[a]);
    end
    chk({power_stage_en, standby_en, 1'b0, boost_db}, 8'hc6);
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      v = {6'h25, k[1:0]};
      host.wr(8'h01, v);
      host.rd(8'h01, q);
      chk(q, v);
      chk({clip_threshold_hi, amp_sleep, amp_power_on_n}, v);
      chk({6'h00, power_stage_en, standby_en}, {6'h00, k[0] & ~k[1], k[0]});
    end
    $display("power control done");
    for (int k = 0; k < 6; k++) begin
      v = {k[0], 1'b0, k[1:0], k[1], k[2:0]};
      host.wr(8'h02, v);
      host.rd(8'h02, q);
      chk(q, v);
      chk({highpass_skip, 1'b0, digital_boost, rate_speed_select, input_format}, v);
      chk({3'h0, boost_db}, {6'h00, k[1:0]} * 8'h06);
      chk({1'b0, fmt_i2s, fmt_left_just, sample_width}, {1'b0, k == 4, k == 5, wtab[k]});
    end
    $display("digital path done");
    for (int k = 0; k < 4; k++) begin
      v = {~k[0], 5'h00, k[1:0]};
      host.wr(8'h03, v | 8'h7c);
      host.rd(8'h03, q);
      chk(q, v);
      chk({fade_enable, 5'h00, mute_right, mute_left}, v);
      chk({6'h00, bal_right, bal_left}, {6'h00, k[1:0]});
    end
    host.wr(8'h00, 8'h00);
    host.rd(8'h00, q);
    chk(q, ID_VALUE);
    chk(host.ack_miss, 8'h00);
    // A frozen device must neither answer nor store a write.
    ce <= 1'b0;
    host.wr(8'h03, 8'h80);
    ce <= 1'b1;
    host.rd(8'h03, q);
    chk(q, 8'h03);
    chk(host.ack_miss, 8'h03);
    $display("volume and identity done");
    stop_test();
  end

  // Watchdog: the sequence needs about 30000 clocks.
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
endmodule // actl_reg_bank_test

`default_nettype wire
